// ---- hdl/afe_ctrl_pkg.sv ----
package afe_ctrl_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] off_line_mode = 8'h00;
    localparam logic [7:0] off_sync_detect = 8'h04;
    localparam logic [7:0] off_block_disable = 8'h08;
    localparam logic [7:0] off_power_ctrl = 8'h0c;
    localparam logic [7:0] off_soft_reset = 8'h10;
    localparam logic [7:0] off_cycle_reset = 8'h14;
    localparam logic [7:0] off_status = 8'h18;
    localparam logic [7:0] off_red_offset = 8'h20;
    localparam logic [7:0] off_green_offset = 8'h24;
    localparam logic [7:0] off_blue_offset = 8'h28;
    localparam logic [7:0] off_all_offset = 8'h2c;
    localparam logic [7:0] off_red_gain = 8'h30;
    localparam logic [7:0] off_green_gain = 8'h34;
    localparam logic [7:0] off_blue_gain = 8'h38;
    localparam logic [7:0] off_all_gain = 8'h3c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int lm_line_seq = 0;
    localparam int lm_auto_cycle = 1;
    localparam int lm_force_en = 2;
    localparam int lm_int_clamp = 3;
    localparam int lm_int_colour_lo = 4;
    localparam int lm_forced_lo = 6;
    localparam int sd_detect_en = 0;
    localparam int sd_delay_lo = 1;
    localparam int sd_polarity = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] line_mode_rst = 8'h00;
    localparam logic [7:0] sync_detect_rst = 8'h00;
    localparam logic [3:0] disable_mask_rst = 4'h0;
    localparam logic [7:0] code_rst = 8'h00;

    localparam logic [1:0] colour_red = 2'h0;
    localparam logic [1:0] colour_green = 2'h1;
    localparam logic [1:0] colour_blue = 2'h2;

endpackage : afe_ctrl_pkg

// ---- hdl/afe_line_mode_and_gain_control_regs.sv ----
// Function
// - Bit 0 selects line-sequential colour mode
// - Line mode forces mono and red pick
// - Line mode disables green and blue amps
// - Auto-cycle bit makes pin advance colour
// - Auto-cycle stops pin clamping
// - Internal clamp bit governs clamping then
// - Force bit steers input mux only
// - Internal colour field, 11 reserved
// - Forced input colour field, 11 reserved
// - Detect enable picks raw or generated pulse
// - Generated pulse delayed by delay field
// - Polarity bit picks detected pin edge
// - Disable mask acts under selective power down
// - Mask bit one disables its block
// - Per-channel 8-bit offset codes
// - Broadcast offset write loads all three
// - Per-channel 8-bit gain codes
// - Broadcast gain write loads all three
// - Cycle reset write returns counter to red
// - Selective power down enables mask
// - Soft reset write restores all defaults
`timescale 1ns/1ns

module afe_line_mode_and_gain_control_regs #(
    parameter int delay_width = 3
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor pins
    input wire logic clamp_or_cycle_pin,
    input wire logic video_sample_pulse,
    // Settings from other setup registers
    input wire logic mono_select,
    input wire logic [1:0] mono_colour_pick,
    // Analogue controls
    output logic mono_effective,
    output logic [1:0] mono_colour_effective,
    output logic [1:0] input_mux_sel,
    output logic [1:0] gain_offset_mux_sel,
    output logic reset_level_clamp,
    output logic timing_sample_pulse,
    output logic red_block_off,
    output logic green_block_off,
    output logic blue_block_off,
    output logic green_amp_off,
    output logic blue_amp_off,
    output logic converter_off,
    output logic [7:0] red_offset,
    output logic [7:0] green_offset,
    output logic [7:0] blue_offset,
    output logic [7:0] red_gain,
    output logic [7:0] green_gain,
    output logic [7:0] blue_gain
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] line_mode;
        logic [7:0] sync_detect;
        logic [3:0] disable_mask;
        logic sel_power_down;
        logic [2:0][7:0] offset_code;
        logic [2:0][7:0] gain_code;
        logic [1:0] cycle_colour;
        logic pin_prev;
        logic [8:0] pulse_shift;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic mono_eff;
        logic [1:0] mono_pick_eff;
        logic [1:0] in_mux;
        logic [1:0] go_mux;
        logic clamp;
        logic sample_out;
        logic [3:0] blk_off;
        logic green_amp_off;
        logic blue_amp_off;
        logic [2:0][7:0] off_out;
        logic [2:0][7:0] gain_out;
    } state_t;

    logic [1:0] rst_sync_q;
    logic rst_n;
    state_t s_q;
    state_t s_d;


    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    // Reset released through two flops to avoid a metastable release
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Next colour of the auto-cycle, wrapping blue back to red
    function automatic logic [1:0] next_colour(input logic [1:0] c);
        next_colour = (c == afe_ctrl_pkg::colour_blue) ? afe_ctrl_pkg::colour_red : 2'(c + 2'h1);
    endfunction : next_colour

    function automatic state_t defaults();
        state_t d;
        d = '0;
        d.line_mode = afe_ctrl_pkg::line_mode_rst;
        d.sync_detect = afe_ctrl_pkg::sync_detect_rst;
        d.disable_mask = afe_ctrl_pkg::disable_mask_rst;
        d.offset_code = {3{afe_ctrl_pkg::code_rst}};
        d.gain_code = {3{afe_ctrl_pkg::code_rst}};
        d.cycle_colour = afe_ctrl_pkg::colour_red;
        d.pready = 1'b1;
        return d;
    endfunction : defaults

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic wr;
        logic rd;
        logic line_seq;
        logic auto_cyc;
        logic det_en;
        logic edge_hit;
        logic [2:0] dly;
        logic [8:0] shift;
        logic [31:0] rdv;
        logic mapped;
        wr = 1'b0;
        rd = 1'b0;
        line_seq = 1'b0;
        auto_cyc = 1'b0;
        det_en = 1'b0;
        edge_hit = 1'b0;
        dly = 3'h0;
        shift = 9'h000;
        rdv = 32'h0;
        mapped = 1'b1;
        s_d = s_q;
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        s_d.pslverr = 1'b0;

        // ----------------------------------------
        // Bus decode
        // ----------------------------------------
        // Register decode, zero wait states
        case (paddr)
            afe_ctrl_pkg::off_line_mode: rdv = {24'h0, s_q.line_mode};
            afe_ctrl_pkg::off_sync_detect: rdv = {27'h0, s_q.sync_detect[4:0]};
            afe_ctrl_pkg::off_block_disable: rdv = {28'h0, s_q.disable_mask};
            afe_ctrl_pkg::off_power_ctrl: rdv = {31'h0, s_q.sel_power_down};
            afe_ctrl_pkg::off_status: rdv = {30'h0, s_q.cycle_colour};
            afe_ctrl_pkg::off_red_offset: rdv = {24'h0, s_q.offset_code[0]};
            afe_ctrl_pkg::off_green_offset: rdv = {24'h0, s_q.offset_code[1]};
            afe_ctrl_pkg::off_blue_offset: rdv = {24'h0, s_q.offset_code[2]};
            afe_ctrl_pkg::off_red_gain: rdv = {24'h0, s_q.gain_code[0]};
            afe_ctrl_pkg::off_green_gain: rdv = {24'h0, s_q.gain_code[1]};
            afe_ctrl_pkg::off_blue_gain: rdv = {24'h0, s_q.gain_code[2]};
            afe_ctrl_pkg::off_soft_reset,
            afe_ctrl_pkg::off_cycle_reset,
            afe_ctrl_pkg::off_all_offset,
            afe_ctrl_pkg::off_all_gain: rdv = 32'h0;
            default: mapped = 1'b0;
        endcase
        // Answer loaded in the setup cycle so it stands through the access phase
        if (rd)
            s_d.prdata = rdv;
        if (psel && !penable && !mapped)
            s_d.pslverr = 1'b1;

        // ----------------------------------------
        // Register writes
        // ----------------------------------------

        if (wr)
        begin
            case (paddr)
                afe_ctrl_pkg::off_line_mode: s_d.line_mode = pwdata[7:0];
                afe_ctrl_pkg::off_sync_detect: s_d.sync_detect = {3'h0, pwdata[4:0]};
                afe_ctrl_pkg::off_block_disable: s_d.disable_mask = pwdata[3:0];
                afe_ctrl_pkg::off_power_ctrl: s_d.sel_power_down = pwdata[0];
                afe_ctrl_pkg::off_red_offset: s_d.offset_code[0] = pwdata[7:0];
                afe_ctrl_pkg::off_green_offset: s_d.offset_code[1] = pwdata[7:0];
                afe_ctrl_pkg::off_blue_offset: s_d.offset_code[2] = pwdata[7:0];
                afe_ctrl_pkg::off_all_offset: s_d.offset_code = {3{pwdata[7:0]}};
                afe_ctrl_pkg::off_red_gain: s_d.gain_code[0] = pwdata[7:0];
                afe_ctrl_pkg::off_green_gain: s_d.gain_code[1] = pwdata[7:0];
                afe_ctrl_pkg::off_blue_gain: s_d.gain_code[2] = pwdata[7:0];
                afe_ctrl_pkg::off_all_gain: s_d.gain_code = {3{pwdata[7:0]}};
                default: s_d.line_mode = s_d.line_mode;
            endcase
        end

        // ----------------------------------------
        // Auto-cycle
        // ----------------------------------------

        line_seq = s_q.line_mode[afe_ctrl_pkg::lm_line_seq];
        auto_cyc = line_seq && s_q.line_mode[afe_ctrl_pkg::lm_auto_cycle];

        if (auto_cyc && clamp_or_cycle_pin && !s_q.pin_prev)
            s_d.cycle_colour = next_colour(s_q.cycle_colour);
        if (wr && paddr == afe_ctrl_pkg::off_cycle_reset)
            s_d.cycle_colour = afe_ctrl_pkg::colour_red;
        s_d.pin_prev = clamp_or_cycle_pin;

        // ----------------------------------------
        // Effective controls
        // ----------------------------------------

        s_d.mono_eff = line_seq ? 1'b1 : mono_select;
        s_d.mono_pick_eff = line_seq ? afe_ctrl_pkg::colour_red : mono_colour_pick;

        // colour for gain and offset: mono pick, cycle colour or internal colour field
        if (!line_seq)
            s_d.go_mux = mono_colour_pick;
        else if (auto_cyc)
            s_d.go_mux = s_q.cycle_colour;
        else
            s_d.go_mux = s_q.line_mode[afe_ctrl_pkg::lm_int_colour_lo +: 2];
        if (line_seq && s_q.line_mode[afe_ctrl_pkg::lm_force_en])
            s_d.in_mux = s_q.line_mode[afe_ctrl_pkg::lm_forced_lo +: 2];
        else
            s_d.in_mux = s_d.go_mux;

        s_d.clamp = auto_cyc ? s_q.line_mode[afe_ctrl_pkg::lm_int_clamp] : clamp_or_cycle_pin;

        // ----------------------------------------
        // Power down
        // ----------------------------------------

        s_d.green_amp_off = line_seq;
        s_d.blue_amp_off = line_seq;

        s_d.blk_off = s_q.sel_power_down ? s_q.disable_mask : 4'h0;

        // ----------------------------------------
        // Sample pulse
        // ----------------------------------------

        det_en = s_q.sync_detect[afe_ctrl_pkg::sd_detect_en];
        dly = s_q.sync_detect[afe_ctrl_pkg::sd_delay_lo +: 3];
        edge_hit = s_q.sync_detect[afe_ctrl_pkg::sd_polarity]
            ? (video_sample_pulse && !s_q.pulse_shift[0])
            : (!video_sample_pulse && s_q.pulse_shift[0]);
        // delay by field periods
        // Nine taps so the longest delay of seven still has a stage to read
        shift = {s_q.pulse_shift[7:1], edge_hit, video_sample_pulse};
        s_d.pulse_shift = shift;
        s_d.sample_out = det_en ? shift[4'(dly) + 4'h1] : video_sample_pulse;

        s_d.off_out = s_d.offset_code;
        s_d.gain_out = s_d.gain_code;

        // ----------------------------------------
        // Soft reset
        // ----------------------------------------

        if (wr && paddr == afe_ctrl_pkg::off_soft_reset)
        begin
            s_d = defaults();
            s_d.pin_prev = clamp_or_cycle_pin;
            // Derived controls keep following their inputs, as in normal mode
            s_d.mono_eff = mono_select;
            s_d.mono_pick_eff = mono_colour_pick;
            s_d.go_mux = mono_colour_pick;
            s_d.in_mux = mono_colour_pick;
            s_d.clamp = clamp_or_cycle_pin;
            s_d.sample_out = video_sample_pulse;
            s_d.pulse_shift[0] = video_sample_pulse;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Clock enable low freezes the bus as well, so a master must hold its request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '{pready: 1'b1, default: '0};
        else if (clk_en)
            s_q <= s_d;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;

    // ----------------------------------------
    // Analogue controls
    // ----------------------------------------
    assign mono_effective = s_q.mono_eff;
    assign mono_colour_effective = s_q.mono_pick_eff;
    assign input_mux_sel = s_q.in_mux;
    assign gain_offset_mux_sel = s_q.go_mux;
    assign reset_level_clamp = s_q.clamp;
    assign timing_sample_pulse = s_q.sample_out;

    // ----------------------------------------
    // Block disables
    // ----------------------------------------
    assign red_block_off = s_q.blk_off[0];
    assign green_block_off = s_q.blk_off[1];
    assign blue_block_off = s_q.blk_off[2];
    assign converter_off = s_q.blk_off[3];
    assign green_amp_off = s_q.green_amp_off;
    assign blue_amp_off = s_q.blue_amp_off;

    // ----------------------------------------
    // Offset and gain codes
    // ----------------------------------------
    assign red_offset = s_q.off_out[0];
    assign green_offset = s_q.off_out[1];
    assign blue_offset = s_q.off_out[2];
    assign red_gain = s_q.gain_out[0];
    assign green_gain = s_q.gain_out[1];
    assign blue_gain = s_q.gain_out[2];

endmodule : afe_line_mode_and_gain_control_regs

// ---- test/apb_host.sv ----
`timescale 1ns/1ns
module apb_host (
    // Clock and answer
    input wire logic sys_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Request
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0
);
    // Answer is taken at the edge that completes the access, then the request is released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk iff pready === 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host

// ---- test/afe_regs_checker.sv ----
`timescale 1ns/1ns
module afe_regs_checker (
    // Watched ports
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic clamp_or_cycle_pin,
    input wire logic mono_select,
    input wire logic mono_effective,
    input wire logic [1:0] mono_colour_effective,
    input wire logic reset_level_clamp,
    input wire logic green_amp_off,
    input wire logic blue_amp_off,
    input wire logic [7:0] red_offset,
    input wire logic [7:0] green_offset,
    input wire logic [7:0] blue_offset,
    input wire logic [7:0] red_gain,
    input wire logic [7:0] green_gain,
    input wire logic [7:0] blue_gain
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Derived controls lag the bus, so only stored codes are tied to the write edge
    wire logic wr_acc = psel && penable && pwrite;
    amp_pair_a: assert property (green_amp_off == blue_amp_off)
        else $error("amplifier controls differ");
    line_force_a: assert property (green_amp_off |-> mono_effective && mono_colour_effective == 2'h0)
        else $error("line mode did not force mono pick");
    mono_pass_a: assert property (!green_amp_off |-> mono_effective == $past(mono_select))
        else $error("mono select not passed in normal mode");
    clamp_pass_a: assert property (!green_amp_off |-> reset_level_clamp == $past(clamp_or_cycle_pin))
        else $error("clamp pin not passed in normal mode");
    bcast_off_a: assert property (wr_acc && paddr == afe_ctrl_pkg::off_all_offset |=>
        red_offset == $past(pwdata[7:0]) && green_offset == red_offset && blue_offset == red_offset)
        else $error("broadcast offset not loaded");
    bcast_gain_a: assert property (wr_acc && paddr == afe_ctrl_pkg::off_all_gain |=>
        red_gain == $past(pwdata[7:0]) && green_gain == red_gain && blue_gain == red_gain)
        else $error("broadcast gain not loaded");
    chan_code_a: assert property (wr_acc && paddr == afe_ctrl_pkg::off_red_gain |=>
        red_gain == $past(pwdata[7:0]) && $stable(green_gain))
        else $error("red gain write wrong");
    soft_rst_a: assert property (wr_acc && paddr == afe_ctrl_pkg::off_soft_reset |=>
        {red_offset, green_offset, blue_offset, red_gain, green_gain, blue_gain} == 48'h0)
        else $error("soft reset left codes");
    cover property (wr_acc && paddr == afe_ctrl_pkg::off_all_gain);
    cover property (green_amp_off && reset_level_clamp);
    cover property (wr_acc && paddr == afe_ctrl_pkg::off_soft_reset);
endmodule : afe_regs_checker

bind afe_line_mode_and_gain_control_regs afe_regs_checker chk_i (.*);

// ---- test/afe_line_mode_and_gain_control_regs_tb.sv ----
`timescale 1ns/1ns
module afe_line_mode_and_gain_control_regs_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clamp_or_cycle_pin = 1'b0;
    logic video_sample_pulse = 1'b0;
    logic mono_select = 1'b0;
    logic [1:0] mono_colour_pick = 2'h0;
    logic [1:0] cnt = 2'h0;
    logic psel, penable, pwrite, pready, pslverr, mono_effective, reset_level_clamp, timing_sample_pulse, e;
    logic red_block_off, green_block_off, blue_block_off, green_amp_off, blue_amp_off, converter_off;
    logic [1:0] mono_colour_effective, input_mux_sel, gain_offset_mux_sel, g;
    logic [7:0] paddr, red_offset, green_offset, blue_offset, red_gain, green_gain, blue_gain;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] m [0:15] = '{default: 8'h00};
    // Writable bits per word; action and broadcast words read as zero, status is not writable
    logic [7:0] wm [0:15] = '{8'hff, 8'h1f, 8'h0f, 8'h01, 0, 0, 0, 0, 8'hff, 8'hff, 8'hff, 0, 8'hff, 8'hff, 8'hff, 0};
    int mismatches = 0;
    int n_checks = 0;
    int seed = 6016;
    int n, b;
    afe_line_mode_and_gain_control_regs dut (.clk_en(1'b1), .*);
    apb_host host (.*);
    initial forever #10 sys_clk = ~sys_clk;
    initial
    begin
        #200000;
        mismatches++;
        results;
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        n_checks++;
        if (y !== x)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'($random(seed)), d}, q, e);
        m[a[5:2]] = d & wm[a[5:2]];
        for (int i = 8; i < 15; i++)
            if (a == 8'h2c && i < 11 || a == 8'h3c && i > 11)
                m[i] = d;
        if (a == 8'h10)
            m = '{default: 8'h00};
        if (a == 8'h10 || a == 8'h14)
            cnt = 2'h0;
    endtask : wr
    task automatic outs;
        repeat (4) @(negedge sys_clk);
        g = !m[0][0] ? mono_colour_pick : m[0][1] ? cnt : m[0][5:4];
        chk("ofs", {m[10], m[9], m[8]}, {blue_offset, green_offset, red_offset});
        chk("gain", {m[14], m[13], m[12]}, {blue_gain, green_gain, red_gain});
        chk("line", {m[0][0], m[0][0], m[0][0] | mono_select, m[0][0] ? 2'h0 : mono_colour_pick},
            {green_amp_off, blue_amp_off, mono_effective, mono_colour_effective});
        chk("mux", {(m[0][0] & m[0][2]) ? m[0][7:6] : g, g}, {input_mux_sel, gain_offset_mux_sel});
        chk("clamp", (m[0][0] & m[0][1]) ? m[0][3] : clamp_or_cycle_pin, reset_level_clamp);
        chk("blk", m[3][0] ? m[2][3:0] : 4'h0,
            {converter_off, blue_block_off, green_block_off, red_block_off});
    endtask : outs
    task automatic rdall;
        for (int a = 0; a < 64; a += 4)
            if (a != 24 && a != 28)
            begin
                host.xfer(1'b0, 8'(a), 32'h0, q, e);
                chk("rd", m[a / 4], q);
            end
        outs;
    endtask : rdall
    task automatic tog;
        @(posedge sys_clk);
        clamp_or_cycle_pin <= ~clamp_or_cycle_pin;
        if (!clamp_or_cycle_pin && m[0][1:0] == 2'h3)
            cnt = cnt == 2'h2 ? 2'h0 : cnt + 2'h1;
        outs;
    endtask : tog
    // The opposite edge comes first and is left to die out before the measured edge
    task automatic lat(input logic v, output int k);
        @(posedge sys_clk);
        video_sample_pulse <= ~v;
        repeat (12) @(posedge sys_clk);
        video_sample_pulse <= v;
        @(negedge sys_clk);
        for (k = 1; k < 20 && timing_sample_pulse !== 1'b1; k++)
            @(negedge sys_clk);
    endtask : lat
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdall;
        $display("test reset done");
        repeat (24)
        begin
            wr(8'h20 + 8'({$random(seed)} % 8 * 4), 8'($random(seed)));
            outs;
        end
        rdall;
        host.xfer(1'b0, 8'h1c, 32'h0, q, e);
        chk("err", 1'b1, e);
        $display("test codes done");
        // Colour fields stay off the reserved code 11
        for (int c = 0; c < 9; c++)
        begin
            @(posedge sys_clk);
            mono_select <= 1'($random(seed));
            mono_colour_pick <= 2'($random(seed));
            wr(8'h00, {2'(c / 3), 2'(c % 3), 4'($random(seed)) & 4'hd});
            rdall;
        end
        $display("test line mode done");
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h00, {4'h6, 1'(k), 3'h7});
            wr(8'h14, 8'h00);
            repeat (7) tog;
            host.xfer(1'b0, 8'h18, 32'h0, q, e);
            chk("cyc", cnt, q);
            wr(8'h14, 8'h00);
            outs;
        end
        $display("test auto cycle done");
        repeat (4)
        begin
            wr(8'h08, 8'($random(seed)));
            outs;
            wr(8'h0c, 8'($random(seed)));
            outs;
        end
        $display("test power down done");
        wr(8'h04, 8'h00);
        lat(1'b1, n);
        chk("raw", 2, n);
        for (int p = 0; p < 2; p++)
        begin
            wr(8'h04, {3'h0, 1'(p), 4'h1});
            lat(1'(p), b);
            for (int d = 1; d < 8; d += 3)
            begin
                wr(8'h04, {3'h0, 1'(p), 3'(d), 1'b1});
                lat(1'(p), n);
                chk("dly", b + d, n);
            end
            lat(1'(1 - p), n);
            chk("edge", 20, n);
        end
        $display("test detect done");
        wr(8'h10, 8'h00);
        rdall;
        $display("test soft reset done");
        results;
    end
endmodule : afe_line_mode_and_gain_control_regs_tb
